// >>> hw/svs_regs.svh
// Offsets, field positions and timing constants of the slave verification status words.
`ifndef SVS_REGS_SVH
`define SVS_REGS_SVH

// =====================================================================
// Word offsets within the status area
// =====================================================================
`define SVS_OFS_VERIFY_STATUS   4'h4
`define SVS_OFS_STOP_CAUSE      4'h5
`define SVS_OFS_OUT_MISSING     4'h6
`define SVS_OFS_IN_MISSING      4'h7
`define SVS_OFS_OUT_UNREG       4'h8
`define SVS_OFS_IN_UNREG        4'h9

// =====================================================================
// Field positions
// =====================================================================
`define SVS_BIT_REG_DONE        0
`define SVS_BIT_MISSING         8
`define SVS_BIT_UNREG           9
`define SVS_BIT_STOPPED         10
`define SVS_BIT_ERROR           15
`define SVS_NODE_LSB            0
`define SVS_NODE_MSB            7
`define SVS_BIT_STOP_TYPE       15

// =====================================================================
// Reset values and timing
// =====================================================================
`define SVS_WORD_RESET          16'h0000
`define SVS_MON_TIME_US         10000
`define SVS_CLK_MHZ             100

`endif

// >>> hw/svs_pkg.sv
// Types shared by the slave verification status design.
package svs_pkg;

  typedef enum logic [1:0] {
    SVS_MONITOR,
    SVS_RUN
  } svs_phase_t;

  typedef enum logic {
    SVS_TYPE_OUTPUT,
    SVS_TYPE_INPUT
  } svs_slave_type_t;

endpackage : svs_pkg

// >>> hw/svs_first_set.sv
// Finds the lowest set bit of a vector and reports its index.
module svs_first_set #(
  parameter int W  = 16,
  parameter int IW = 8
) (
  input  wire logic [W-1:0]  vec_i,
  output logic               any_o,
  output logic [IW-1:0]      idx_o
);

  always_comb begin
    any_o = 1'b0;
    idx_o = '0;
    for (int i = W - 1; i >= 0; i--) begin
      if (vec_i[i]) begin
        any_o = 1'b1;
        idx_o = IW'(i);
      end
    end
  end

endmodule : svs_first_set

// >>> hw/svs_node_track.sv
// Per-node verification tracking for one class of slaves (output or input).
module svs_node_track
  import svs_pkg::*;
#(
  parameter int N = 16
) (
  input  wire logic         clock_i,
  input  wire logic         rst_n_i,
  input  wire logic         ce_i,
  input  wire logic         restart_i,
  input  wire logic         enable_i,
  input  wire logic         expire_i,
  input  wire logic [N-1:0] registered_i,
  input  wire logic [N-1:0] joined_i,
  output logic      [N-1:0] seen_o,
  output logic      [N-1:0] missing_o,
  output logic      [N-1:0] unreg_o
);

  logic [N-1:0] seen_r;
  logic [N-1:0] missing_r;
  logic [N-1:0] unreg_r;

  assign seen_o    = seen_r;
  assign missing_o = missing_r;
  assign unreg_o   = unreg_r;

  // =====================================================================
  // Participation history
  // =====================================================================
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      seen_r <= '0;
    end else if (ce_i) begin
      if (restart_i) begin
        seen_r <= '0;
      end else begin
        seen_r <= seen_r | joined_i;
      end
    end
  end

  // =====================================================================
  // Missing slaves: marked at expiry, cleared when the slave joins
  // =====================================================================
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      missing_r <= '0;
    end else if (ce_i) begin
      if (restart_i || !enable_i) begin
        missing_r <= '0;
      end else if (expire_i) begin
        missing_r <= registered_i & ~(seen_r | joined_i); // [RULE3] [RULE5]
      end else begin
        missing_r <= missing_r & ~joined_i; // [RULE4]
      end
    end
  end

  // =====================================================================
  // Unregistered slaves: latched until reset, restart or enable_i low
  // =====================================================================
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      unreg_r <= '0;
    end else if (ce_i) begin
      if (restart_i || !enable_i) begin
        unreg_r <= '0;
      end else begin
        unreg_r <= unreg_r | (joined_i & ~registered_i); // [RULE6] [RULE7]
      end
    end
  end

endmodule : svs_node_track

// >>> hw/svs_status.sv
// Slave verification and communications-stop status words of the network master.
//
// Behaviour
// [RULE1] Set word 4 bit 0 when all registered slaves join within monitoring time.
// [RULE2] Never set registration complete while the registration table is empty.
// [RULE3] Set word 4 bit 8 when a registered slave misses the monitoring time.
// [RULE4] Clear the missing indication once the missing slave joins.
// [RULE5] Mark each missing slave by node in word 6 (output) or 7 (input).
// [RULE6] Latch word 4 bit 9 when an unregistered slave joins.
// [RULE7] Mark each unregistered slave by node in word 8 (output) or 9 (input).
// [RULE8] In stop mode, set word 4 bit 10 when exchange halts on error.
// [RULE9] Hold the communications-stopped flag until reset or restart.
// [RULE10] Word 4 bit 15 is the OR of bits 8 to 10.
// [RULE11] On a stop, store the offending node number in word 5 bits 0 to 7.
// [RULE12] Keep the stored node number until reset or restart.
// [RULE13] On a stop, word 5 bit 15 gives slave type: 0 output, 1 input.
// [RULE14] Keep the stored slave type until reset or restart.
// [RULE15] In stop mode, halt exchange when any slave error flag is set.
// [RULE16] Reset and unit restart clear every flag and field to zero.
`include "svs_regs.svh"

module svs_status
  import svs_pkg::*;
#(
  parameter int N           = 16,
  parameter int MON_TIME_US = `SVS_MON_TIME_US
) (
  input  wire logic         clock_i,
  input  wire logic         nrst_i,
  input  wire logic         ce_i,
  input  wire logic         restart_i,
  input  wire logic         reg_func_en_i,
  input  wire logic         stop_mode_i,
  input  wire logic [N-1:0] reg_out_i,
  input  wire logic [N-1:0] reg_in_i,
  input  wire logic [N-1:0] join_out_i,
  input  wire logic [N-1:0] join_in_i,
  input  wire logic [N-1:0] err_out_i,
  input  wire logic [N-1:0] err_in_i,
  output logic      [15:0]  verify_status_word_o,
  output logic      [15:0]  stop_cause_word_o,
  output logic      [N-1:0] out_missing_word_o,
  output logic      [N-1:0] in_missing_word_o,
  output logic      [N-1:0] out_unreg_word_o,
  output logic      [N-1:0] in_unreg_word_o,
  output logic              comm_halt_o
);

  // =====================================================================
  // Timing
  // =====================================================================
  localparam longint MON_CYCLES_RAW = longint'(MON_TIME_US) * `SVS_CLK_MHZ;
  localparam logic [31:0] MON_CYCLES =
    (MON_CYCLES_RAW < 1) ? 32'h0000_0001 : 32'(MON_CYCLES_RAW);

  // =====================================================================
  // Reset release
  // =====================================================================
  logic rst_meta_r;
  logic rst_n_r;

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  // =====================================================================
  // Participation monitoring window
  // =====================================================================
  svs_phase_t  phase_r;
  logic [31:0] mon_cnt_r;
  logic        expire;

  assign expire = (phase_r == SVS_MONITOR) && (mon_cnt_r == MON_CYCLES - 32'h0000_0001);

  always_ff @(posedge clock_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      phase_r   <= SVS_MONITOR;
      mon_cnt_r <= 32'h0000_0000;
    end else if (ce_i) begin
      if (restart_i) begin
        phase_r   <= SVS_MONITOR;
        mon_cnt_r <= 32'h0000_0000;
      end else begin
        case (phase_r)
          SVS_MONITOR: begin
            if (expire) begin
              phase_r <= SVS_RUN;
            end else begin
              mon_cnt_r <= mon_cnt_r + 32'h0000_0001;
            end
          end
          SVS_RUN: begin
            phase_r <= SVS_RUN;
          end
          default: begin
            phase_r <= SVS_MONITOR;
          end
        endcase
      end
    end
  end

  // =====================================================================
  // Per-node tracking for output and input slaves
  // =====================================================================
  logic [N-1:0] seen_out;
  logic [N-1:0] seen_in;
  logic [N-1:0] miss_out;
  logic [N-1:0] miss_in;
  logic [N-1:0] unreg_out;
  logic [N-1:0] unreg_in;

  svs_node_track #(.N(N)) u_track_out (
    .clock_i      (clock_i),
    .rst_n_i      (rst_n_r),
    .ce_i         (ce_i),
    .restart_i    (restart_i),
    .enable_i     (reg_func_en_i),
    .expire_i     (expire),
    .registered_i (reg_out_i),
    .joined_i     (join_out_i),
    .seen_o       (seen_out),
    .missing_o    (miss_out),
    .unreg_o      (unreg_out)
  );

  svs_node_track #(.N(N)) u_track_in (
    .clock_i      (clock_i),
    .rst_n_i      (rst_n_r),
    .ce_i         (ce_i),
    .restart_i    (restart_i),
    .enable_i     (reg_func_en_i),
    .expire_i     (expire),
    .registered_i (reg_in_i),
    .joined_i     (join_in_i),
    .seen_o       (seen_in),
    .missing_o    (miss_in),
    .unreg_o      (unreg_in)
  );

  // =====================================================================
  // Registration complete flag
  // =====================================================================
  logic reg_done_r;
  logic table_used;
  logic all_joined;

  assign table_used = (|reg_out_i) || (|reg_in_i);
  assign all_joined = ((reg_out_i & ~(seen_out | join_out_i)) == '0) &&
                      ((reg_in_i & ~(seen_in | join_in_i)) == '0);

  always_ff @(posedge clock_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      reg_done_r <= 1'b0;
    end else if (ce_i) begin
      if (restart_i) begin
        reg_done_r <= 1'b0; // [RULE16]
      end else if (reg_func_en_i && (phase_r == SVS_MONITOR) && table_used && all_joined) begin
        reg_done_r <= 1'b1; // [RULE1] [RULE2]
      end
    end
  end

  // =====================================================================
  // Communications stop capture
  // =====================================================================
  logic       any_out_err;
  logic       any_in_err;
  logic [7:0] node_out;
  logic [7:0] node_in;
  logic       stopped_r;
  logic [7:0] stop_node_r;
  logic       stop_type_r;

  svs_first_set #(.W(N), .IW(8)) u_first_out (
    .vec_i (err_out_i),
    .any_o (any_out_err),
    .idx_o (node_out)
  );

  svs_first_set #(.W(N), .IW(8)) u_first_in (
    .vec_i (err_in_i),
    .any_o (any_in_err),
    .idx_o (node_in)
  );

  always_ff @(posedge clock_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      stopped_r   <= 1'b0;
      stop_node_r <= 8'h00;
      stop_type_r <= 1'b0;
    end else if (ce_i) begin
      if (restart_i) begin
        stopped_r   <= 1'b0; // [RULE16]
        stop_node_r <= 8'h00;
        stop_type_r <= 1'b0;
      end else if (!stopped_r && stop_mode_i && (any_out_err || any_in_err)) begin
        stopped_r <= 1'b1; // [RULE8] [RULE15]
        // Output slaves take precedence when both classes fail together.
        stop_node_r <= any_out_err ? node_out : node_in; // [RULE11]
        stop_type_r <= any_out_err ? SVS_TYPE_OUTPUT : SVS_TYPE_INPUT; // [RULE13]
      end
      // Once stopped, the flag, node and type hold. [RULE9] [RULE12] [RULE14]
    end
  end

  // =====================================================================
  // Status words
  // =====================================================================
  logic [15:0] status_nxt;
  logic [15:0] cause_nxt;

  always_comb begin
    status_nxt                    = `SVS_WORD_RESET;
    status_nxt[`SVS_BIT_REG_DONE] = reg_done_r;
    status_nxt[`SVS_BIT_MISSING]  = (|miss_out) || (|miss_in); // [RULE3] [RULE4]
    status_nxt[`SVS_BIT_UNREG]    = (|unreg_out) || (|unreg_in); // [RULE6]
    status_nxt[`SVS_BIT_STOPPED]  = stopped_r; // [RULE8]
    status_nxt[`SVS_BIT_ERROR]    = (|miss_out) || (|miss_in) || (|unreg_out) ||
                                    (|unreg_in) || stopped_r; // [RULE10]
    cause_nxt                                  = `SVS_WORD_RESET;
    cause_nxt[`SVS_NODE_MSB:`SVS_NODE_LSB]     = stop_node_r; // [RULE11]
    cause_nxt[`SVS_BIT_STOP_TYPE]              = stop_type_r; // [RULE13]
  end

  always_ff @(posedge clock_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      verify_status_word_o <= `SVS_WORD_RESET; // [RULE16]
    end else if (ce_i) begin
      verify_status_word_o <= status_nxt;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      stop_cause_word_o <= `SVS_WORD_RESET;
    end else if (ce_i) begin
      stop_cause_word_o <= cause_nxt;
    end
  end

  // =====================================================================
  // Per-node words
  // =====================================================================
  always_ff @(posedge clock_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      out_missing_word_o <= '0;
    end else if (ce_i) begin
      out_missing_word_o <= miss_out; // [RULE5]
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      in_missing_word_o <= '0;
    end else if (ce_i) begin
      in_missing_word_o <= miss_in;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      out_unreg_word_o <= '0;
    end else if (ce_i) begin
      out_unreg_word_o <= unreg_out; // [RULE7]
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      in_unreg_word_o <= '0;
    end else if (ce_i) begin
      in_unreg_word_o <= unreg_in;
    end
  end

  // =====================================================================
  // Remote exchange halt
  // =====================================================================
  always_ff @(posedge clock_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      comm_halt_o <= 1'b0;
    end else if (ce_i) begin
      comm_halt_o <= stopped_r; // [RULE15]
    end
  end

endmodule : svs_status

// >>> dv/svs_status_asserts.sv
// Port checker of the slave verification status words.
module svs_status_asserts
  import svs_pkg::*;
#(
  parameter int N           = 16,
  parameter int MON_TIME_US = 1
) (
  input wire logic         clock_i,
  input wire logic         nrst_i,
  input wire logic         ce_i,
  input wire logic         restart_i,
  input wire logic         stop_mode_i,
  input wire logic [N-1:0] reg_out_i,
  input wire logic [N-1:0] reg_in_i,
  input wire logic [N-1:0] err_out_i,
  input wire logic [N-1:0] err_in_i,
  input wire logic [15:0]  verify_status_word_o,
  input wire logic [15:0]  stop_cause_word_o,
  input wire logic [N-1:0] out_missing_word_o,
  input wire logic [N-1:0] in_missing_word_o,
  input wire logic [N-1:0] out_unreg_word_o,
  input wire logic [N-1:0] in_unreg_word_o,
  input wire logic         comm_halt_o
);
  logic [15:0] v;
  logic        any_reg;
  logic        any_out;
  assign v = verify_status_word_o;
  assign any_reg = |{reg_out_i, reg_in_i};
  assign any_out = |{v, stop_cause_word_o, out_missing_word_o, in_missing_word_o,
                     out_unreg_word_o, in_unreg_word_o, comm_halt_o};
  default clocking @(posedge clock_i);
  endclocking
  default disable iff (!nrst_i);
  // ====
  // Checks
  sequence stop_req_s;
    stop_mode_i && ce_i && !restart_i && (|{err_out_i, err_in_i});
  endsequence
  sequence restart_s;
    restart_i && ce_i ##1 ce_i;
  endsequence
  stop_set_a:
    assert property (stop_req_s ##1 ce_i |=> v[10]) else $error("stop flag late");
  stop_hold_a:
    assert property (v[10] && !$past(restart_i) |=> v[10] && $stable(stop_cause_word_o))
    else $error("stop record lost");
  restart_clr_a:
    assert property (restart_s |=> !any_out) else $error("restart left state");
  err_sum_a:
    assert property (v[15] == |v[10:8]) else $error("error flag wrong");
  miss_sum_a:
    assert property (v[8] == |{out_missing_word_o, in_missing_word_o})
    else $error("missing flag wrong");
  unreg_sum_a:
    assert property (v[9] == |{out_unreg_word_o, in_unreg_word_o}) else $error("unreg flag wrong");
  halt_tie_a:
    assert property (comm_halt_o == v[10]) else $error("halt and flag differ");
  empty_tab_a:
    assert property ($rose(v[0]) |-> $past(any_reg, 2)) else $error("done with empty table");
  done_hold_a:
    assert property (v[0] && !$past(restart_i) |=> v[0]) else $error("done flag dropped");
  stop_node_a:
    assert property ($rose(v[10]) |-> stop_cause_word_o[14:4] == 11'h000)
    else $error("stop node out of range");
endmodule : svs_status_asserts

bind svs_status svs_status_asserts #(.N(N), .MON_TIME_US(MON_TIME_US)) chk_u (
  .clock_i(clock_i), .nrst_i(nrst_i), .ce_i(ce_i), .restart_i(restart_i),
  .stop_mode_i(stop_mode_i), .reg_out_i(reg_out_i), .reg_in_i(reg_in_i),
  .err_out_i(err_out_i), .err_in_i(err_in_i), .verify_status_word_o(verify_status_word_o),
  .stop_cause_word_o(stop_cause_word_o), .out_missing_word_o(out_missing_word_o),
  .in_missing_word_o(in_missing_word_o), .out_unreg_word_o(out_unreg_word_o),
  .in_unreg_word_o(in_unreg_word_o), .comm_halt_o(comm_halt_o)
);

// >>> dv/svs_slave_net.sv
// Behavioural model of the remote output and input slaves.
module svs_slave_net (
  input  wire logic        clock_i,
  input  wire logic        slow_i,
  input  wire logic [15:0] want_out_i,
  input  wire logic [15:0] want_in_i,
  input  wire logic [15:0] fail_out_i,
  input  wire logic [15:0] fail_in_i,
  output logic      [15:0] join_out_o = 16'h0000,
  output logic      [15:0] join_in_o = 16'h0000,
  output logic      [15:0] err_out_o = 16'h0000,
  output logic      [15:0] err_in_o = 16'h0000
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] po;
  logic [15:0] pi;
  assign po = want_out_i & ~join_out_o;
  assign pi = want_in_i & ~join_in_o;
  // A slow network admits one waiting node of each class per cycle, lowest first.
  always @(posedge clock_i) begin
    join_out_o <= (slow_i ? join_out_o & want_out_i | po & -po : want_out_i) & ~fail_out_i;
    join_in_o <= (slow_i ? join_in_o & want_in_i | pi & -pi : want_in_i) & ~fail_in_i;
    err_out_o <= fail_out_i;
    err_in_o <= fail_in_i;
  end
endmodule : svs_slave_net

// >>> dv/svs_status_bench.sv
// Self-checking bench of the slave verification status words.
module svs_status_bench import svs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [15:0] w4, w5, mo, mi, uo, ui;} svs_note_t;
  localparam logic [15:0] Z = 16'h0000;
  logic        clock_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic        ce = 1'b1;
  logic        rst = 1'b0;
  logic        fen = 1'b1;
  logic        smode = 1'b0;
  logic        slow = 1'b0;
  logic [15:0] ro = Z, ri = Z, wo = Z, wi = Z, fo = Z, fi = Z;
  wire  [15:0] jo, ji, eo, ei, w4, w5, mo, mi, uo, ui;
  wire         halt;
  integer      seed = 18089;
  int          miscompares = 0;
  int          tests_run = 0;
  int          k;
  int          j;
  svs_note_t   notes[$];
  svs_note_t   n;

  always #5 clock_i = ~clock_i;

  svs_status #(.N(16), .MON_TIME_US(1)) dut_u (
    .clock_i(clock_i), .nrst_i(nrst_i), .ce_i(ce), .restart_i(rst), .reg_func_en_i(fen),
    .stop_mode_i(smode), .reg_out_i(ro), .reg_in_i(ri), .join_out_i(jo), .join_in_i(ji),
    .err_out_i(eo), .err_in_i(ei), .verify_status_word_o(w4), .stop_cause_word_o(w5),
    .out_missing_word_o(mo), .in_missing_word_o(mi), .out_unreg_word_o(uo),
    .in_unreg_word_o(ui), .comm_halt_o(halt)
  );
  svs_slave_net net_u (
    .clock_i(clock_i), .slow_i(slow), .want_out_i(wo), .want_in_i(wi), .fail_out_i(fo),
    .fail_in_i(fi), .join_out_o(jo), .join_in_o(ji), .err_out_o(eo), .err_in_o(ei)
  );

  // ====
  // Tasks
  task automatic tick(input int cyc);
    repeat (cyc) begin
      @(negedge clock_i);
      ce = ($random(seed) % 8) != 0;
    end
  endtask : tick

  task automatic unit_restart;
    @(negedge clock_i);
    ce = 1'b1;
    rst = 1'b1;
    @(negedge clock_i);
    rst = 1'b0;
  endtask : unit_restart

  task automatic want(input int cyc, input logic [15:0] a, b, c, d, e, f);
    tick(cyc);
    notes.push_back('{a, b, c, d, e, f});
  endtask : want

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic end_of_test;
    $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test

  always @(negedge clock_i) begin
    while (notes.size() > 0) begin
      n = notes.pop_front();
      cmp(w4, n.w4);
      cmp(w5, n.w5);
      cmp(mo, n.mo);
      cmp(mi, n.mi);
      cmp(uo, n.uo);
      cmp(ui, n.ui);
      cmp({15'h0000, halt}, {15'h0000, n.w4[10]});
    end
  end

  // ====
  // Scenarios
  initial begin
    repeat (12) @(negedge clock_i);
    nrst_i = 1'b1;
    wo = 16'h0004;
    want(130, 16'h8200, Z, Z, Z, 16'h0004, Z);
    wo = Z;
    want(20, 16'h8200, Z, Z, Z, 16'h0004, Z);
    unit_restart;
    want(20, Z, Z, Z, Z, Z, Z);
    fen = 1'b0;
    wo = 16'h0004;
    want(20, Z, Z, Z, Z, Z, Z);
    $display("done: empty table");
    for (int i = 0; i < 2; i++) begin
      ro = 16'($random(seed)) & 16'h7FFF | 16'h0001;
      ri = 16'($random(seed));
      slow = i[0];
      fen = 1'b1;
      wo = ro;
      wi = ri;
      unit_restart;
      want(130, 16'h0001, Z, Z, Z, Z, Z);
      wo = ro | 16'h8000;
      want(20, 16'h8201, Z, Z, Z, 16'h8000, Z);
    end
    $display("done: registration complete");
    k = $unsigned($random(seed)) % 15;
    j = $unsigned($random(seed)) % 16;
    ro = 16'($random(seed)) | 16'h0001 << k;
    ri = 16'($random(seed)) | 16'h0001 << j;
    wo = ro & ~(16'h0001 << k);
    wi = ri & ~(16'h0001 << j);
    slow = 1'b0;
    unit_restart;
    want(160, 16'h8100, Z, 16'h0001 << k, 16'h0001 << j, Z, Z);
    wo = ro;
    want(20, 16'h8100, Z, Z, 16'h0001 << j, Z, Z);
    wi = ri;
    want(20, Z, Z, Z, Z, Z, Z);
    $display("done: missing slaves");
    ro = Z;
    ri = Z;
    wo = Z;
    wi = Z;
    smode = 1'b1;
    fo = 16'h8000 | 16'h0001 << k;
    fi = 16'h0001 << j;
    unit_restart;
    want(20, 16'h8400, 16'(k), Z, Z, Z, Z);
    fo = Z;
    fi = 16'h0001;
    want(20, 16'h8400, 16'(k), Z, Z, Z, Z);
    unit_restart;
    want(20, 16'h8400, 16'h8000, Z, Z, Z, Z);
    smode = 1'b0;
    unit_restart;
    want(20, Z, Z, Z, Z, Z, Z);
    $display("done: communications stop");
    tick(2);
    end_of_test;
  end

  initial begin
    #50000;
    miscompares++;
    end_of_test;
  end
endmodule : svs_status_bench
